// ===== design/ccpc_defs.svh
// Register map, field positions, reset values and stabilisation counts of the clock controller.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CCPC_DEFS_SVH
`define CCPC_DEFS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CCPC_OFF_POWER_CONTROL 8'h00
`define CCPC_OFF_CLOCK_STATUS  8'h0C
`define CCPC_OFF_CLOCK_SELECT0 8'h10
`define CCPC_OFF_PLL_CONTROL   8'h20
`define CCPC_OFF_FREQ_DIVIDER  8'h24
`define CCPC_OFF_IRQ_STATUS    8'h28
`define CCPC_OFF_IRQ_CLEAR     8'h2C
`define CCPC_OFF_IRQ_ENABLE    8'h30
// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define CCPC_RST_POWER_CONTROL 32'h0000_000C
`define CCPC_MSK_POWER_CONTROL 32'h0000_000D
`define CCPC_RST_CLOCK_SELECT0 32'h0000_003F
`define CCPC_MSK_CLOCK_SELECT0 32'h0000_003F
`define CCPC_RST_PLL_CONTROL   32'h0005_C22E
`define CCPC_RST_FREQ_DIVIDER  32'h0000_0000
`define CCPC_MSK_FREQ_DIVIDER  32'h0000_003F
`define CCPC_MSK_IRQ           5'h1F
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCPC_BIT_CRYSTAL_EN    0
`define CCPC_BIT_FAST_RC_EN    2
`define CCPC_BIT_SLOW_RC_EN    3
`define CCPC_BIT_WAKEUP_IRQ_EN 5
`define CCPC_BIT_WAKEUP_STS    6
`define CCPC_BIT_PLL_POWERDN   16
`define CCPC_BIT_PLL_REF_SEL   19
`define CCPC_BIT_DIV_EN        4
`define CCPC_BIT_DIV_BYPASS    5
// ----------------------------------------------------------------------------
// Clock source select codes and stabilisation counts
// ----------------------------------------------------------------------------
`define CCPC_SEL_CRYSTAL 3'h0
`define CCPC_SEL_PLL     3'h2
`define CCPC_SEL_SLOW_RC 3'h3
`define CCPC_SEL_FAST_RC 3'h7
`define CCPC_STABLE_CRYSTAL 13'h1000
`define CCPC_STABLE_PLL     13'h1800
`define CCPC_STABLE_FAST_RC 13'h0100
`define CCPC_STABLE_SLOW_RC 13'h0001
`endif

// ===== design/ccpc_pkg.sv
// Types shared by the clock controller.
// Assumes the constants header sits beside it.
package ccpc_pkg;
  `include "ccpc_defs.svh"
  typedef enum logic [0:0] {CCPC_RUN = 1'b0, CCPC_DOWN = 1'b1} ccpc_pm_type;
  typedef enum logic [1:0] {
    CCPC_IX_CRYSTAL = 2'b00,
    CCPC_IX_PLL     = 2'b01,
    CCPC_IX_SLOW_RC = 2'b10,
    CCPC_IX_FAST_RC = 2'b11
  } ccpc_src_type;
endpackage : ccpc_pkg

// ===== design/ccpc_top.sv
// Chip clock and power controller: source enables, stability counters, glitch-free
// clock selection, deep power-down, divided clock output, AXI4-Lite registers.
// Assumes oscillator and PLL levels arrive asynchronously and are slower than CLK / 2.
//
// What this block does
// - Enter power-down only on sleep instruction with deep-sleep select; leave on wake-up
// - In power-down switch off crystal and fast RC oscillator
// - PLL reference is crystal when select bit 0, fast RC when 1
// - Enabling a source starts its counter; terminal count sets its stable flag
// - Counts: crystal 4096, PLL 6144 reference, fast RC 256, slow RC 1
// - A source drives system or peripheral clock only once stable
// - Disabling a source clears its stable flag at once
// - Power-down clears crystal, fast RC, PLL flags; counters restart after wake-up
// - System clock chosen from four sources by select field bits 2..0
// - Tick clock chosen from four sources by select field bits 5..3
// - In power-down slow RC and watchdog clock keep running; others stop
// - Divider is sixteen divide-by-two stages with a sixteen-way output mux
// - Output frequency is input over two to the power N plus one
// - Enable starts chain; disable runs until output low then holds low
// - Bypass bit, with enable set, passes divider input clock straight to the output pin
// - Wake-up sets status flag, cleared by writing one; interrupt when enabled
`timescale 1ns/1ps
`include "ccpc_defs.svh"
module ccpc_top
  import ccpc_pkg::*;
#(
  parameter logic [12:0] XTL_STABLE_CNT = `CCPC_STABLE_CRYSTAL,
  parameter logic [12:0] PLL_STABLE_CNT = `CCPC_STABLE_PLL
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        WAIT_FOR_IRQ_INSTR,
  input  wire logic        DEEP_SLEEP_SELECT,
  input  wire logic        WAKEUP_REQ,
  input  wire logic        EXT_CRYSTAL_OSC,
  input  wire logic        PLL_OUTPUT_CLOCK,
  input  wire logic        SLOW_RC_OSC,
  input  wire logic        FAST_RC_OSC,
  output logic             CRYSTAL_ENABLE,
  output logic             FAST_RC_ENABLE,
  output logic             SLOW_RC_ENABLE,
  output logic             PLL_POWER_DOWN,
  output logic             PLL_REF_SELECT,
  output logic             SYS_CLK,
  output logic             TICK_CLOCK,
  output logic             WDT_CLK,
  output logic             CLOCK_OUTPUT_PIN,
  output logic             POWER_DOWN,
  output logic             IRQ
);
  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [1:0] sel_idx(input logic [2:0] sel);
    case (sel)
      `CCPC_SEL_CRYSTAL: sel_idx = CCPC_IX_CRYSTAL;
      `CCPC_SEL_PLL:     sel_idx = CCPC_IX_PLL;
      `CCPC_SEL_SLOW_RC: sel_idx = CCPC_IX_SLOW_RC;
      default:           sel_idx = CCPC_IX_FAST_RC;
    endcase
  endfunction : sel_idx

  function automatic logic sel_ok(input logic [2:0] sel);
    sel_ok = (sel == `CCPC_SEL_CRYSTAL) || (sel == `CCPC_SEL_PLL) ||
             (sel == `CCPC_SEL_SLOW_RC) || (sel == `CCPC_SEL_FAST_RC);
  endfunction : sel_ok

  // Switch only when the target is stable and both old and new levels are low
  function automatic logic sw_ok(input logic [2:0] req, input logic [2:0] cur,
                                 input logic [3:0] lvl, input logic [3:0] stb);
    sw_ok = (req != cur) && stb[sel_idx(req)] && !lvl[sel_idx(req)] && !lvl[sel_idx(cur)];
  endfunction : sw_ok

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = strb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : wmerge

  // --------------------------------------------------------------------------
  // Source synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] meta_ff;
  logic [3:0] lvl_ff;
  logic [3:0] lvl_prev_ff;
  logic [3:0] src_pin;
  logic [3:0] rise;
  assign src_pin = {FAST_RC_OSC, SLOW_RC_OSC, PLL_OUTPUT_CLOCK, EXT_CRYSTAL_OSC};
  assign rise    = lvl_ff & ~lvl_prev_ff;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_ff     <= 4'h0;
      lvl_ff      <= 4'h0;
      lvl_prev_ff <= 4'h0;
    end else begin
      meta_ff     <= src_pin;
      lvl_ff      <= meta_ff;
      lvl_prev_ff <= lvl_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Registers and AXI4-Lite slave
  // --------------------------------------------------------------------------
  logic [31:0] pwr_ff, sel0_ff, pll_ff, fdiv_ff;
  logic [31:0] nxt_pwr, nxt_sel0, nxt_pll, nxt_fdiv;
  logic [4:0]  ien_ff, ists_ff, nxt_ien, nxt_ists, irq_ev;
  logic        aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic        nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [3:0]  stb_ff, nxt_stb;
  logic        do_wr;
  logic [31:0] wv;

  assign AWREADY = !aw_got_ff;
  assign WREADY  = !w_got_ff;
  assign ARREADY = !rvalid_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;
  assign do_wr   = aw_got_ff && w_got_ff && !bvalid_ff;
  assign IRQ     = |(ists_ff & ien_ff);

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_got  = w_got_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    nxt_pwr    = pwr_ff;
    nxt_sel0   = sel0_ff;
    nxt_pll    = pll_ff;
    nxt_fdiv   = fdiv_ff;
    nxt_ien    = ien_ff;
    nxt_ists   = ists_ff;
    wv         = wmerge(32'h0000_0000, wdata_ff, wstrb_ff);
    if (AWVALID && !aw_got_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = AWADDR;
    end
    if (WVALID && !w_got_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = WDATA;
      nxt_wstrb = WSTRB;
    end
    if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = 2'b00;
      case (awaddr_ff)
        `CCPC_OFF_POWER_CONTROL: begin
          nxt_pwr = wmerge(pwr_ff, wdata_ff, wstrb_ff) & `CCPC_MSK_POWER_CONTROL;
          if (wstrb_ff[0]) begin
            nxt_ien[0] = wdata_ff[`CCPC_BIT_WAKEUP_IRQ_EN];
          end
          nxt_ists[0] = ists_ff[0] & ~wv[`CCPC_BIT_WAKEUP_STS];
        end
        `CCPC_OFF_CLOCK_SELECT0: nxt_sel0 = wmerge(sel0_ff, wdata_ff, wstrb_ff) & `CCPC_MSK_CLOCK_SELECT0;
        `CCPC_OFF_PLL_CONTROL:   nxt_pll  = wmerge(pll_ff, wdata_ff, wstrb_ff);
        `CCPC_OFF_FREQ_DIVIDER:  nxt_fdiv = wmerge(fdiv_ff, wdata_ff, wstrb_ff) & `CCPC_MSK_FREQ_DIVIDER;
        `CCPC_OFF_IRQ_CLEAR:     nxt_ists = ists_ff & ~wv[4:0];
        `CCPC_OFF_IRQ_ENABLE:    nxt_ien  = wv[4:0] & `CCPC_MSK_IRQ;
        `CCPC_OFF_CLOCK_STATUS, `CCPC_OFF_IRQ_STATUS: nxt_bresp = 2'b00;
        default:                 nxt_bresp = 2'b10;
      endcase
    end
    nxt_ists = nxt_ists | irq_ev;  // Set wins over a clear in the same cycle
    if (rvalid_ff && RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (ARVALID && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = 2'b00;
      case (ARADDR)
        `CCPC_OFF_POWER_CONTROL: nxt_rdata = pwr_ff | {25'h0, ists_ff[0], ien_ff[0], 5'h00};
        `CCPC_OFF_CLOCK_STATUS:  nxt_rdata = {27'h0, stb_ff[3], stb_ff[2], stb_ff[1], 1'b0, stb_ff[0]};
        `CCPC_OFF_CLOCK_SELECT0: nxt_rdata = sel0_ff;
        `CCPC_OFF_PLL_CONTROL:   nxt_rdata = pll_ff;
        `CCPC_OFF_FREQ_DIVIDER:  nxt_rdata = fdiv_ff;
        `CCPC_OFF_IRQ_STATUS:    nxt_rdata = {27'h0, ists_ff};
        `CCPC_OFF_IRQ_CLEAR:     nxt_rdata = 32'h0000_0000;
        `CCPC_OFF_IRQ_ENABLE:    nxt_rdata = {27'h0, ien_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_got_ff  <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'b00;
      pwr_ff    <= `CCPC_RST_POWER_CONTROL;
      sel0_ff   <= `CCPC_RST_CLOCK_SELECT0;
      pll_ff    <= `CCPC_RST_PLL_CONTROL;
      fdiv_ff   <= `CCPC_RST_FREQ_DIVIDER;
      ien_ff    <= 5'h00;
      ists_ff   <= 5'h00;
    end else begin
      aw_got_ff <= nxt_aw_got;
      awaddr_ff <= nxt_awaddr;
      w_got_ff  <= nxt_w_got;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      pwr_ff    <= nxt_pwr;
      sel0_ff   <= nxt_sel0;
      pll_ff    <= nxt_pll;
      fdiv_ff   <= nxt_fdiv;
      ien_ff    <= nxt_ien;
      ists_ff   <= nxt_ists;
    end
  end

  // --------------------------------------------------------------------------
  // Power-down control and stability counters
  // --------------------------------------------------------------------------
  ccpc_pm_type pm_ff, nxt_pm;
  logic [12:0] cnt_ff [4];
  logic [12:0] nxt_cnt [4];
  logic [12:0] lim [4];
  logic [3:0]  en_eff, cedge;
  logic        down, wake_ev;

  assign down      = (pm_ff == CCPC_DOWN);
  assign wake_ev   = down && WAKEUP_REQ;
  assign lim[0]    = XTL_STABLE_CNT;
  assign lim[1]    = PLL_STABLE_CNT;
  assign lim[2]    = `CCPC_STABLE_SLOW_RC;
  assign lim[3]    = `CCPC_STABLE_FAST_RC;
  assign en_eff[0] = pwr_ff[`CCPC_BIT_CRYSTAL_EN] && !down;
  assign en_eff[1] = !pll_ff[`CCPC_BIT_PLL_POWERDN] && !down;
  assign en_eff[2] = pwr_ff[`CCPC_BIT_SLOW_RC_EN];
  assign en_eff[3] = pwr_ff[`CCPC_BIT_FAST_RC_EN] && !down;
  // PLL settles on edges of its reference, not its own output
  assign cedge     = {rise[3], rise[2], pll_ff[`CCPC_BIT_PLL_REF_SEL] ? rise[3] : rise[0], rise[0]};
  assign irq_ev    = {nxt_stb & ~stb_ff, 1'b0} | {4'h0, wake_ev};

  assign CRYSTAL_ENABLE = en_eff[0];
  assign FAST_RC_ENABLE = en_eff[3];
  assign SLOW_RC_ENABLE = en_eff[2];
  assign PLL_POWER_DOWN = !en_eff[1];
  assign PLL_REF_SELECT = pll_ff[`CCPC_BIT_PLL_REF_SEL];
  assign POWER_DOWN     = down;

  always_comb begin
    nxt_pm = pm_ff;
    case (pm_ff)
      CCPC_RUN:  if (WAIT_FOR_IRQ_INSTR && DEEP_SLEEP_SELECT) nxt_pm = CCPC_DOWN;
      CCPC_DOWN: if (WAKEUP_REQ) nxt_pm = CCPC_RUN;
      default:   nxt_pm = CCPC_RUN;
    endcase
    for (int i = 0; i < 4; i++) begin
      nxt_cnt[i] = cnt_ff[i];
      nxt_stb[i] = stb_ff[i];
      if (!en_eff[i]) begin
        nxt_cnt[i] = 13'h0000;
        nxt_stb[i] = 1'b0;
      end else if (!stb_ff[i] && cedge[i]) begin
        if (cnt_ff[i] == lim[i] - 13'h0001) begin
          nxt_stb[i] = 1'b1;
        end else begin
          nxt_cnt[i] = cnt_ff[i] + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pm_ff  <= CCPC_RUN;
      stb_ff <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= 13'h0000;
      end
    end else begin
      pm_ff  <= nxt_pm;
      stb_ff <= nxt_stb;
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock selection and frequency divider
  // --------------------------------------------------------------------------
  logic [2:0]  sys_cur_ff, tick_cur_ff, nxt_sys_cur, nxt_tick_cur, sys_req, tick_req;
  logic        sys_out_ff, tick_out_ff, wdt_ff, clock_output_pin_ff, run_ff, sys_prev_ff;
  logic        nxt_sys_out, nxt_tick_out, nxt_wdt, nxt_clock_output_pin, nxt_run;
  logic [15:0] div_cnt_ff, nxt_div_cnt;
  logic [3:0]  nsel;

  assign sys_req          = sel_ok(sel0_ff[2:0]) ? sel0_ff[2:0] : sys_cur_ff;
  assign tick_req         = sel_ok(sel0_ff[5:3]) ? sel0_ff[5:3] : tick_cur_ff;
  assign nsel             = fdiv_ff[3:0];
  assign SYS_CLK          = sys_out_ff;
  assign TICK_CLOCK       = tick_out_ff;
  assign WDT_CLK          = wdt_ff;
  assign CLOCK_OUTPUT_PIN = clock_output_pin_ff;

  always_comb begin
    nxt_sys_cur  = sw_ok(sys_req, sys_cur_ff, lvl_ff, stb_ff) ? sys_req : sys_cur_ff;
    nxt_tick_cur = sw_ok(tick_req, tick_cur_ff, lvl_ff, stb_ff) ? tick_req : tick_cur_ff;
    // Gated by the stable flag so an unsettled source never reaches logic
    // Looks at the next power state so no clock pulse leaks into the first power-down cycle
    nxt_sys_out  = (nxt_pm == CCPC_RUN) && stb_ff[sel_idx(sys_cur_ff)] && lvl_ff[sel_idx(sys_cur_ff)];
    nxt_tick_out = (nxt_pm == CCPC_RUN) && stb_ff[sel_idx(tick_cur_ff)] && lvl_ff[sel_idx(tick_cur_ff)];
    nxt_wdt      = stb_ff[CCPC_IX_SLOW_RC] && lvl_ff[CCPC_IX_SLOW_RC];
    // Chain runs on enable, then only while the output is still high, so a low pin never rises again
    nxt_run      = fdiv_ff[`CCPC_BIT_DIV_EN] || (run_ff && clock_output_pin_ff);
    nxt_div_cnt  = div_cnt_ff;
    if (nxt_run && sys_out_ff && !sys_prev_ff) begin
      nxt_div_cnt = div_cnt_ff + 16'h0001;
    end
    if (fdiv_ff[`CCPC_BIT_DIV_BYPASS]) begin
      nxt_clock_output_pin = fdiv_ff[`CCPC_BIT_DIV_EN] && sys_out_ff;
    end else begin
      nxt_clock_output_pin = nxt_run && nxt_div_cnt[nsel];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sys_cur_ff  <= `CCPC_SEL_FAST_RC;
      tick_cur_ff <= `CCPC_SEL_FAST_RC;
      sys_out_ff  <= 1'b0;
      tick_out_ff <= 1'b0;
      wdt_ff      <= 1'b0;
      clock_output_pin_ff     <= 1'b0;
      run_ff      <= 1'b0;
      sys_prev_ff <= 1'b0;
      div_cnt_ff  <= 16'h0000;
    end else begin
      sys_cur_ff  <= nxt_sys_cur;
      tick_cur_ff <= nxt_tick_cur;
      sys_out_ff  <= nxt_sys_out;
      tick_out_ff <= nxt_tick_out;
      wdt_ff      <= nxt_wdt;
      clock_output_pin_ff     <= nxt_clock_output_pin;
      run_ff      <= nxt_run;
      sys_prev_ff <= sys_out_ff;
      div_cnt_ff  <= nxt_div_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_pd_entry;
    !down && WAIT_FOR_IRQ_INSTR && DEEP_SLEEP_SELECT |=> down;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");
  property p_pd_stay;
    down && !WAKEUP_REQ |=> down;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left without wake-up");
  property p_osc_off;
    down |-> !CRYSTAL_ENABLE && !FAST_RC_ENABLE && !SYS_CLK ##1 !SYS_CLK || !down;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("fast sources alive in power-down");
  property p_slow_one;
    en_eff[2] && !stb_ff[2] && rise[2] |=> stb_ff[2];
  endproperty
  a_slow_one: assert property (p_slow_one) else $error("slow source not stable after one edge");
  property p_fast_count;
    en_eff[3] && !stb_ff[3] && cnt_ff[3] == 13'h00FF && rise[3] |=> stb_ff[3];
  endproperty
  a_fast_count: assert property (p_fast_count) else $error("fast source count wrong");
  property p_early;
    en_eff[3] && cnt_ff[3] < 13'h00FF |=> !stb_ff[3] || $past(stb_ff[3]);
  endproperty
  a_early: assert property (p_early) else $error("fast source stable too early");
  property p_use_stable;
    SYS_CLK |-> $past(stb_ff[sel_idx(sys_cur_ff)]);
  endproperty
  a_use_stable: assert property (p_use_stable) else $error("system clock from unstable source");
  property p_disable_clr;
    !pwr_ff[`CCPC_BIT_CRYSTAL_EN] |=> !stb_ff[0];
  endproperty
  a_disable_clr: assert property (p_disable_clr) else $error("crystal flag kept after disable");
  property p_down_clr;
    down |=> !stb_ff[0] && !stb_ff[1] && !stb_ff[3];
  endproperty
  a_down_clr: assert property (p_down_clr) else $error("flags kept in power-down");
  property p_glitch;
    $changed(sys_cur_ff) |-> !$past(lvl_ff[sel_idx(sys_cur_ff)]) && stb_ff[sel_idx(sys_cur_ff)] || !ARST_N;
  endproperty
  a_glitch: assert property (p_glitch) else $error("unsafe clock switch");
  property p_div_hold;
    !fdiv_ff[`CCPC_BIT_DIV_EN] && !fdiv_ff[`CCPC_BIT_DIV_BYPASS] && !CLOCK_OUTPUT_PIN |=> !CLOCK_OUTPUT_PIN;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider output rose while disabled");
  property p_wake_flag;
    down && WAKEUP_REQ |=> ists_ff[0] && (!ien_ff[0] || IRQ);
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake-up status not set");

  c_sleep_wake: cover property (!down ##1 down [*2] ##1 !down);
  c_sys_switch: cover property ($changed(sys_cur_ff));
  c_clock_output_pin_rise:  cover property (!clock_output_pin_ff ##1 clock_output_pin_ff);
  c_irq:        cover property (!IRQ ##1 IRQ);
endmodule : ccpc_top

// ===== tb/ccpc_osc_model.sv
// Oscillators and PLL beside the clock controller.
// Assumes enables from the controller; outputs toggle at CLK / 4 or slower.
`timescale 1ns/1ps
module ccpc_osc_model (
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic CRYSTAL_ENABLE,
  input  wire logic FAST_RC_ENABLE,
  input  wire logic SLOW_RC_ENABLE,
  input  wire logic PLL_POWER_DOWN,
  input  wire logic PLL_REF_SELECT,
  output logic      EXT_CRYSTAL_OSC,
  output logic      FAST_RC_OSC,
  output logic      SLOW_RC_OSC,
  output logic      PLL_OUTPUT_CLOCK
);
  logic [2:0] cnt_ff;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) cnt_ff <= 3'h0;
    else cnt_ff <= cnt_ff + 3'h1;
  end
  // A stopped oscillator sits low, so stale edges cannot be counted
  assign EXT_CRYSTAL_OSC = CRYSTAL_ENABLE & cnt_ff[1];
  assign FAST_RC_OSC     = FAST_RC_ENABLE & cnt_ff[1];
  assign SLOW_RC_OSC     = SLOW_RC_ENABLE & cnt_ff[2];
  // PLL runs only on a live reference
  assign PLL_OUTPUT_CLOCK = !PLL_POWER_DOWN & (PLL_REF_SELECT ? FAST_RC_ENABLE : CRYSTAL_ENABLE) & cnt_ff[1];
endmodule : ccpc_osc_model

// ===== tb/tb_chip_clock_power_controller.sv
// Self-checking bench of the clock controller.
// Assumes the oscillator model; short crystal and PLL stable counts of 4.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_chip_clock_power_controller;
  import ccpc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} ccpc_row_type;
  logic CLK = 0, ARST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic WAIT_FOR_IRQ_INSTR = 0, DEEP_SLEEP_SELECT = 0, WAKEUP_REQ = 0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [3:0] WSTRB = 4'hF;
  logic [1:0] BRESP, RRESP, rr, br;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, EXT_CRYSTAL_OSC, PLL_OUTPUT_CLOCK, SLOW_RC_OSC, FAST_RC_OSC;
  logic CRYSTAL_ENABLE, FAST_RC_ENABLE, SLOW_RC_ENABLE, PLL_POWER_DOWN, PLL_REF_SELECT;
  logic SYS_CLK, TICK_CLOCK, WDT_CLK, CLOCK_OUTPUT_PIN, POWER_DOWN, IRQ;
  int errors = 0, checks = 0, s = 0, o = 0, t = 0, w = 0, i;
  ccpc_row_type rows [8] = '{'{8'h00, 32'h0000000C, 2'h0}, '{8'h10, 32'h0000003F, 2'h0},
    '{8'h20, 32'h0005C22E, 2'h0}, '{8'h24, 32'h0, 2'h0}, '{8'h30, 32'h0, 2'h0},
    '{8'h2C, 32'h0, 2'h0}, '{8'h04, 32'h0, 2'h2}, '{8'h3C, 32'h0, 2'h2}};
  ccpc_top #(.XTL_STABLE_CNT(13'h0004), .PLL_STABLE_CNT(13'h0004)) DUT (.*);
  ccpc_osc_model MODEL (.*);
  initial begin
    forever #25 CLK = ~CLK;
  end
  always @(posedge SYS_CLK) s++;
  always @(posedge CLOCK_OUTPUT_PIN) o++;
  always @(posedge TICK_CLOCK) t++;
  always @(posedge WDT_CLK) w++;
  task automatic complete_run;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    br = BRESP;
    BREADY <= 1'b0;
    if (n == 100) begin errors++; complete_run(); end
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
    if (n == 100) begin errors++; complete_run(); end
  endtask : rd_reg
  // Polls the status word; a source that never settles ends the run
  task automatic wait_stat(input logic [31:0] m);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd_reg(8'h0C);
      if ((rd & m) === m) break;
    end
    if (n == 3000) begin errors++; complete_run(); end
  endtask : wait_stat
  task automatic sleep_req;
    @(posedge CLK);
    WAIT_FOR_IRQ_INSTR <= 1'b1;
    @(posedge CLK);
    WAIT_FOR_IRQ_INSTR <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : sleep_req
  initial begin
    repeat (4) @(posedge CLK);
    ARST_N <= 1'b1;
    `CHK({CRYSTAL_ENABLE, FAST_RC_ENABLE, SLOW_RC_ENABLE, PLL_POWER_DOWN, PLL_REF_SELECT, POWER_DOWN}, 6'b011100)
    for (i = 0; i < 8; i++) begin
      rd_reg(rows[i].a);
      `CHK({rr, rd}, {rows[i].r, rows[i].d})
    end
    wait_stat(32'h18);
    `CHK(rd, 32'h00000018)
    wr(8'h00, 32'h0000000D);
    wr(8'h20, 32'h0004C22E);
    wait_stat(32'h1D);
    `CHK(rd, 32'h0000001D)
    wr(8'h00, 32'h0000000C);
    wr(8'h20, 32'h0005C22E);
    rd_reg(8'h0C);
    `CHK({rd[2], rd[0]}, 2'b00)
    wr(8'h20, 32'h000CC22E);
    wait_stat(32'h14);
    `CHK({rd[2], rd[0], PLL_REF_SELECT}, 3'b101)
    // Slow RC runs at half the fast rate in the model
    wr(8'h10, 32'h0000001B);
    repeat (16) @(posedge CLK);
    s = 0;
    t = 0;
    repeat (800) @(posedge CLK);
    `CHK({s >= 99 && s <= 101, t >= 99 && t <= 101}, 2'b11)
    wr(8'h10, 32'h0000003F);
    repeat (16) @(posedge CLK);
    // Edge counts over long windows; phase slop allows one output period
    for (i = 0; i < 4; i += 3) begin
      wr(8'h24, 32'h10 | i);
      s = 0;
      o = 0;
      repeat (1600) @(posedge CLK);
      `CHK((o * (2 << i) >= s - (2 << i)) && (o * (2 << i) <= s + (2 << i)), 1'b1)
    end
    wr(8'h24, 32'h00000030);
    s = 0;
    o = 0;
    repeat (400) @(posedge CLK);
    `CHK((o >= s - 1) && (o <= s + 1), 1'b1)
    wr(8'h24, 32'h00000003);
    repeat (40) @(posedge CLK);
    o = 0;
    repeat (200) @(posedge CLK);
    `CHK({o == 0, CLOCK_OUTPUT_PIN}, 2'b10)
    wr(8'h30, 32'h00000001);
    sleep_req();
    `CHK(POWER_DOWN, 1'b0)
    DEEP_SLEEP_SELECT <= 1'b1;
    sleep_req();
    `CHK({POWER_DOWN, FAST_RC_ENABLE, CRYSTAL_ENABLE, IRQ, SLOW_RC_ENABLE, PLL_POWER_DOWN}, 6'b100011)
    s = 0;
    w = 0;
    repeat (40) @(posedge CLK);
    `CHK({s == 0, w >= 4}, 2'b11)
    WAKEUP_REQ <= 1'b1;
    @(posedge CLK);
    WAKEUP_REQ <= 1'b0;
    repeat (2) @(posedge CLK);
    `CHK({POWER_DOWN, IRQ}, 2'b01)
    rd_reg(8'h0C);
    `CHK({rd[4], rd[3]}, 2'b01)
    wr(8'h2C, 32'h00000001);
    @(posedge CLK);
    `CHK({IRQ, br}, 3'b000)
    complete_run();
  end
endmodule : tb_chip_clock_power_controller
